// >>> verilog/avsr_responder.v
// device-side responder for the adaptive voltage link
// assumes link clock and host data are async pins sampled by i_clock
// Operation
// - frame starts with 01b in its two top bits
// - bits 29:28 read 11b, write-hold 01b, write-commit 00b
// - bit 27 set means vendor command, none supported
// - command type decoded: voltage, slew, current, temp, reset, power mode, status, version
// - select A, B or all; broadcast refused for current and temperature
// - 3-bit crc over 29 bits, checked on receive, generated on send
// - ack: good, busy, bad crc, or invalid request
// - response bit 29 zero, bits 7:3 ones
// - response summary: settled, any warning, link owns, reset pin low, zero
// - read value in bits 23:8, ones on writes
// - voltage 1 mV/lsb, writes clamped to min and max, read gives target
// - slew: rise in upper byte, fall in lower byte, independent
// - current read-only, 10 mA per lsb
// - temperature read-only, signed 0.1 degree per lsb
// - voltage reset returns channel or all to boot voltage
// - version read-only broadcast, returns zero
// - no answer during latch-off fault or disabled conversion
// - link warning status independent of management bus status
// - data-out held low between frames while any warning bit is set
// - warning status layout, write one to clear
// - per-phase limit bit needs both clears
// - clock idles low, launch on rise, sample on fall, msb first
// - power mode acknowledged, no action, reads zero
// - voltage commands act only when operation field equals 1100b
`timescale 1ns/1ps
`default_nettype none
`include "avsr_consts.vh"
module avsr_responder
#(
   parameter [15:0] VOUT_MIN = 16'h00fa,
   parameter [15:0] VOUT_MAX = 16'h157c
)
(
   input  wire        i_clock,
   input  wire        i_reset_n,
   input  wire        i_link_clk,
   input  wire        i_link_mdata,
   output wire        o_link_sdata,
   input  wire        i_latchoff_fault,
   input  wire        i_conversion_enabled,
   input  wire        i_reset_pin_low,
   input  wire [3:0]  i_operation_field,
   input  wire [1:0]  i_settled,
   input  wire [31:0] i_current,
   input  wire [31:0] i_temperature,
   input  wire [15:0] i_boot_voltage_a,
   input  wire [15:0] i_boot_voltage_b,
   input  wire [15:0] i_init_voltage,
   input  wire [15:0] i_init_slew,
   input  wire        i_busy,
   input  wire [15:0] i_warning_events,
   input  wire        i_mgmt_clear_faults,
   output wire [15:0] o_link_warning_status,
   output reg  [31:0] o_vout_target_ff,
   output reg  [31:0] o_slew_ff,
   output reg         o_dynamic_voltage_change_ff
);
   //------------------------------------------------------------
   // input synchronisers
   //------------------------------------------------------------
   reg [1:0] clk_s_ff;
   reg [1:0] dat_s_ff;
   reg       clk_d_ff;
   always @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         clk_s_ff <= 2'b00;
         dat_s_ff <= 2'b11;
         clk_d_ff <= 1'b0;
      end
      else
      begin
         clk_s_ff <= {clk_s_ff[0], i_link_clk};
         dat_s_ff <= {dat_s_ff[0], i_link_mdata};
         clk_d_ff <= clk_s_ff[1];
      end
   end
   wire rise = clk_s_ff[1] & ~clk_d_ff;  // launch edge
   wire fall = ~clk_s_ff[1] & clk_d_ff;  // sample edge

   //------------------------------------------------------------
   // crc instances and decode helpers
   //------------------------------------------------------------
   reg  [31:0] rx_ff;
   reg  [5:0]  cnt_ff;
   reg  [31:0] tx_ff;
   reg  [31:0] resp_ff;
   reg         out_ff;
   reg         act_ff;  // frame in flight: from first launch to last sample
   wire [31:0] frame = {rx_ff[30:0], dat_s_ff[1]};
   wire [2:0]  rx_crc;
   wire [2:0]  tx_crc;
   reg  [28:0] resp_body;
   avsr_crc3 u_rx_crc
   (
      .i_bits (frame[31:3]),
      .o_crc  (rx_crc)
   );
   avsr_crc3 u_tx_crc
   (
      .i_bits (resp_body),
      .o_crc  (tx_crc)
   );

   function [15:0] clamp_v;
      input [15:0] v;
      begin
         if (v < VOUT_MIN)
            clamp_v = VOUT_MIN;
         else if (v > VOUT_MAX)
            clamp_v = VOUT_MAX;
         else
            clamp_v = v;
      end
   endfunction

   wire [1:0]  acc  = frame[29:28];
   wire [3:0]  ctyp = frame[26:23];
   wire [3:0]  sel  = frame[22:19];
   wire [15:0] dat  = frame[18:3];
   wire        sel_ok_ch = (sel == `AVSR_SEL_A) || (sel == `AVSR_SEL_B);
   wire        sel_ok_all = sel_ok_ch || (sel == `AVSR_SEL_ALL);
   wire        hit_a = (sel == `AVSR_SEL_A) || (sel == `AVSR_SEL_ALL);
   wire        hit_b = (sel == `AVSR_SEL_B) || (sel == `AVSR_SEL_ALL);
   wire        is_rd = (acc == `AVSR_ACC_READ);
   wire        is_commit = (acc == `AVSR_ACC_COMMIT);
   wire        link_owns_output = (i_operation_field == `AVSR_LINK_OWNS);
   wire        mute = i_latchoff_fault | ~i_conversion_enabled;
   wire        done = (cnt_ff == `AVSR_FRAME_BITS - 6'd1) & fall;

   //------------------------------------------------------------
   // request validity
   //------------------------------------------------------------
   reg valid;
   always @*
   begin
      valid = 1'b0;
      if ((frame[31:30] == `AVSR_START_CODE) && !frame[27]
          && (acc != 2'b10))
      begin
         case (ctyp)
            `AVSR_CMD_VOLT,
            `AVSR_CMD_SLEW:    valid = sel_ok_all;
            `AVSR_CMD_CURR,
            `AVSR_CMD_TEMP:    valid = is_rd & sel_ok_ch;
            `AVSR_CMD_VRESET:  valid = !is_rd & sel_ok_all;
            `AVSR_CMD_PMODE,
            `AVSR_CMD_STATUS:  valid = sel_ok_all;
            `AVSR_CMD_VERSION: valid = is_rd & (sel == `AVSR_SEL_ALL);
            default:           valid = 1'b0;
         endcase
      end
   end

   //------------------------------------------------------------
   // warning status and summary
   //------------------------------------------------------------
   reg  [15:0] warn_ff;
   reg         phlim_mgmt_ff;
   wire [15:0] settled_bit = {|(i_settled), 15'h0000};
   wire        any_warn = |warn_ff;
   wire [4:0]  status_summary = {&i_settled, any_warn, link_owns_output,
                                 i_reset_pin_low, 1'b0};
   assign o_link_warning_status = warn_ff | settled_bit;
   wire st_wr = done & !mute & (frame[31:30] == `AVSR_START_CODE) & valid & !i_busy
                & !is_rd & (ctyp == `AVSR_CMD_STATUS) & (rx_crc == frame[2:0]);

   // separate copy from the management bus flags; only link writes clear it
   always @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         warn_ff <= 16'h0000;
         phlim_mgmt_ff <= 1'b0;
      end
      else
      begin
         if (i_mgmt_clear_faults)
            phlim_mgmt_ff <= 1'b1;
         else if (i_warning_events[`AVSR_STAT_PHLIM])
            phlim_mgmt_ff <= 1'b0;
         if (st_wr)  // new events win over the clear
         begin
            warn_ff <= ((warn_ff & ~(dat & `AVSR_STAT_WMASK))
                       | (i_warning_events & `AVSR_STAT_WMASK));
            if (!(phlim_mgmt_ff | i_mgmt_clear_faults))  // keep bit, new event still sets
               warn_ff[`AVSR_STAT_PHLIM] <= warn_ff[`AVSR_STAT_PHLIM]
                                            | i_warning_events[`AVSR_STAT_PHLIM];
            else if (dat[`AVSR_STAT_PHLIM])
               phlim_mgmt_ff <= 1'b0;
         end
         else
            warn_ff <= warn_ff | (i_warning_events & `AVSR_STAT_WMASK);
      end
   end

   //------------------------------------------------------------
   // frame shift, decode and execution
   //------------------------------------------------------------
   reg [31:0] hold_v_ff;
   reg [31:0] hold_s_ff;
   reg [1:0]  hold_vp_ff;
   reg [1:0]  hold_sp_ff;
   reg [15:0] rdata;
   reg [1:0]  ack;
   wire [15:0] vclamp = clamp_v(dat);
   always @*
   begin
      rdata = `AVSR_READ_DATA;
      case (ctyp)
         `AVSR_CMD_VOLT:    rdata = (sel == `AVSR_SEL_B) ? o_vout_target_ff[31:16]
                                                         : o_vout_target_ff[15:0];
         `AVSR_CMD_SLEW:    rdata = (sel == `AVSR_SEL_B) ? o_slew_ff[31:16] : o_slew_ff[15:0];
         `AVSR_CMD_CURR:    rdata = sel[0] ? i_current[31:16] : i_current[15:0];
         `AVSR_CMD_TEMP:    rdata = sel[0] ? i_temperature[31:16] : i_temperature[15:0];
         `AVSR_CMD_PMODE:   rdata = 16'h0000;
         `AVSR_CMD_STATUS:  rdata = o_link_warning_status;
         `AVSR_CMD_VERSION: rdata = `AVSR_VERSION_VAL;
         default:           rdata = `AVSR_READ_DATA;
      endcase
      if (!is_rd)
         rdata = `AVSR_READ_DATA;
      if (rx_crc != frame[2:0])
         ack = `AVSR_ACK_BADCRC;
      else if (!valid)
         ack = `AVSR_ACK_INVALID;
      else if (i_busy)
         ack = `AVSR_ACK_BUSY;
      else
         ack = `AVSR_ACK_GOOD;
      resp_body = {ack, 1'b0, status_summary, rdata, `AVSR_RSVD_ONES};
   end

   // frame counter, shift registers and resource updates
   always @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_ff <= `AVSR_IDLE_FRAME;
         cnt_ff <= 6'd0;
         tx_ff <= `AVSR_IDLE_FRAME;
         resp_ff <= `AVSR_IDLE_FRAME;
         out_ff <= 1'b1;
         act_ff <= 1'b0;
         o_vout_target_ff <= 32'h0000_0000;
         o_slew_ff <= 32'h0000_0000;
         hold_v_ff <= 32'h0000_0000;
         hold_s_ff <= 32'h0000_0000;
         hold_vp_ff <= 2'b00;
         hold_sp_ff <= 2'b00;
         o_dynamic_voltage_change_ff <= 1'b0;
      end
      else
      begin
         o_dynamic_voltage_change_ff <= 1'b0;
         if (mute)  // frame state abandoned, line released
         begin
            cnt_ff <= 6'd0;
            tx_ff <= `AVSR_IDLE_FRAME;
            out_ff <= 1'b1;
            act_ff <= 1'b0;
         end
         else
         begin
            if (rise)  // launch next bit msb first
            begin
               out_ff <= (cnt_ff == 6'd0) ? resp_ff[31] : tx_ff[31];
               act_ff <= 1'b1;
               if (cnt_ff == 6'd0)
                  tx_ff <= {resp_ff[30:0], 1'b1};
               else
                  tx_ff <= {tx_ff[30:0], 1'b1};
            end
            if (fall)
            begin
               rx_ff <= frame;
               if (done)
                  act_ff <= 1'b0;
               cnt_ff <= done ? 6'd0 : cnt_ff + 6'd1;
            end
            if (done && frame[31:30] == `AVSR_START_CODE)
            begin
               resp_ff <= {resp_body, tx_crc};
               if (ack == `AVSR_ACK_GOOD && !is_rd)
               begin
                  if (ctyp == `AVSR_CMD_VOLT && link_owns_output)
                  begin
                     if (is_commit)  // commit applies the new value, held value dropped
                     begin
                        if (hit_a)
                           o_vout_target_ff[15:0] <= vclamp;
                        if (hit_b)
                           o_vout_target_ff[31:16] <= vclamp;
                        hold_vp_ff <= 2'b00;
                        o_dynamic_voltage_change_ff <= 1'b1;
                     end
                     else
                     begin
                        if (hit_a)
                           hold_v_ff[15:0] <= vclamp;
                        if (hit_b)
                           hold_v_ff[31:16] <= vclamp;
                        hold_vp_ff <= hold_vp_ff | {hit_b, hit_a};
                     end
                  end
                  if (ctyp == `AVSR_CMD_SLEW)
                  begin
                     if (is_commit)
                     begin
                        if (hit_a)
                           o_slew_ff[15:0] <= dat;
                        if (hit_b)
                           o_slew_ff[31:16] <= dat;
                        hold_sp_ff <= 2'b00;
                     end
                     else
                     begin
                        if (hit_a)
                           hold_s_ff[15:0] <= dat;
                        if (hit_b)
                           hold_s_ff[31:16] <= dat;
                        hold_sp_ff <= hold_sp_ff | {hit_b, hit_a};
                     end
                  end
                  if (ctyp == `AVSR_CMD_VRESET && is_commit && link_owns_output)
                  begin
                     if (hit_a)
                        o_vout_target_ff[15:0] <= i_boot_voltage_a;
                     if (hit_b)
                        o_vout_target_ff[31:16] <= i_boot_voltage_b;
                     o_dynamic_voltage_change_ff <= 1'b1;
                  end
               end
            end
            else if (!link_owns_output)
            begin
               // follow the management target while the link does not own it
               o_vout_target_ff <= {i_init_voltage, i_init_voltage};
               o_slew_ff <= {i_init_slew, i_init_slew};
            end
         end
      end
   end

   // between frames the line idles high, or low as an alert while a warning stands
   assign o_link_sdata = mute ? 1'b1 : (act_ff ? out_ff : ~any_warn);
endmodule // avsr_responder
`default_nettype wire

// >>> verilog/avsr_consts.vh
// link responder constants: frame fields, codes, register layout
// assumes inclusion by bare name from design files
`ifndef AVSR_CONSTS_VH
`define AVSR_CONSTS_VH
`define AVSR_FRAME_BITS   6'd32
`define AVSR_START_CODE   2'b01
`define AVSR_ACC_READ     2'b11
`define AVSR_ACC_HOLD     2'b01
`define AVSR_ACC_COMMIT   2'b00
`define AVSR_CMD_VOLT     4'h0
`define AVSR_CMD_SLEW     4'h1
`define AVSR_CMD_CURR     4'h2
`define AVSR_CMD_TEMP     4'h3
`define AVSR_CMD_VRESET   4'h4
`define AVSR_CMD_PMODE    4'h5
`define AVSR_CMD_STATUS   4'he
`define AVSR_CMD_VERSION  4'hf
`define AVSR_SEL_A        4'h0
`define AVSR_SEL_B        4'h1
`define AVSR_SEL_ALL      4'hf
`define AVSR_ACK_GOOD     2'b00
`define AVSR_ACK_BUSY     2'b01
`define AVSR_ACK_BADCRC   2'b10
`define AVSR_ACK_INVALID  2'b11
`define AVSR_READ_DATA    16'hffff
`define AVSR_VERSION_VAL  16'h0000
`define AVSR_RSVD_ONES    5'h1f
`define AVSR_LINK_OWNS    4'hc
`define AVSR_STAT_SETTLED 15
`define AVSR_STAT_PHLIM   4
`define AVSR_STAT_WMASK   16'h70fe
`define AVSR_CRC_SEED     3'h0
`define AVSR_IDLE_FRAME   32'hffff_ffff
`endif

// >>> verilog/avsr_crc3.v
// 3-bit crc (x^3+x+1) over the 29 leading bits of a link frame
// assumes a pure combinational use by the frame responder
`timescale 1ns/1ps
`default_nettype none
`include "avsr_consts.vh"
module avsr_crc3
(
   input  wire [28:0] i_bits,
   output reg  [2:0]  o_crc
);
   integer k;
   reg     fb;
   // msb first serial division unrolled by a loop
   always @*
   begin
      fb = 1'b0;
      o_crc = `AVSR_CRC_SEED;
      for (k = 28; k >= 0; k = k - 1)
      begin
         fb = i_bits[k] ^ o_crc[2];
         o_crc = {o_crc[1], o_crc[0] ^ fb, fb};
      end
   end
endmodule // avsr_crc3
`default_nettype wire

// >>> tb/avsr_host_model.sv
// host side of the voltage link: clocks frames out, collects the answer
// assumes the bench gives it the system clock; link clock is 8 cycles
`timescale 1ns/1ps
`default_nettype none
module avsr_host_model
(
   input  wire logic i_clock,
   input  wire logic i_link_sdata,
   output var  logic o_link_clk,
   output var  logic o_link_mdata
);
   // -------------------------------------------------------------
   // idle levels, then one 32-bit exchange per call
   // -------------------------------------------------------------
   initial
   begin
      o_link_clk   = 1'b0;
      o_link_mdata = 1'b1;
   end

   // answer sampled before the device acts on the fall, so the last bit still stands
   task automatic xfer(input logic [31:0] f, output logic [31:0] r);
      for (int i = 31; i >= 0; i--)
      begin
         @(posedge i_clock);
         o_link_clk   <= 1'b1;
         o_link_mdata <= f[i];
         repeat (4) @(posedge i_clock);
         o_link_clk <= 1'b0;
         repeat (2) @(posedge i_clock);
         @(negedge i_clock);
         r[i] = i_link_sdata;
         @(posedge i_clock);
      end
      @(posedge i_clock);
      o_link_mdata <= 1'b1;
   endtask
endmodule // avsr_host_model
`default_nettype wire

// >>> tb/avsr_chk.sv
// checker for the link responder, bound onto its ports
// assumes one clock domain and an active-low async reset
`timescale 1ns/1ps
`default_nettype none
module avsr_chk #(
   parameter logic [15:0] VOUT_MIN = 16'h00fa,
   parameter logic [15:0] VOUT_MAX = 16'h157c
)
(
   input wire logic        i_clock,
   input wire logic        i_reset_n,
   input wire logic        i_link_clk,
   input wire logic        o_link_sdata,
   input wire logic        i_latchoff_fault,
   input wire logic        i_conversion_enabled,
   input wire logic        i_mgmt_clear_faults,
   input wire logic [3:0]  i_operation_field,
   input wire logic [15:0] i_warning_events,
   input wire logic [15:0] i_init_voltage,
   input wire logic [15:0] o_link_warning_status,
   input wire logic [31:0] o_vout_target_ff
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   logic       mute;
   logic [3:0] idle_ff;
   logic       seen_ff;
   assign mute = i_latchoff_fault | ~i_conversion_enabled;

   // low-clock count saturates, so only a real gap between frames reads idle
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         idle_ff <= 4'h0;
         seen_ff <= 1'b0;
      end
      else
      begin
         idle_ff <= i_link_clk ? 4'h0 : idle_ff + {3'h0, idle_ff != 4'hf};
         seen_ff <= i_mgmt_clear_faults | (seen_ff & ~i_warning_events[4]);
      end
   end

   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   a_mute_quiet: assert property (mute [*3] |-> o_link_sdata)
      else $error("data line driven while muted");
   a_reserved_zero: assert property (o_link_warning_status[11:8] == 4'h0 && !o_link_warning_status[0])
      else $error("fixed status bits not zero");
   a_event_latch: assert property (|(i_warning_events & 16'h70fe) |=>
      (o_link_warning_status & $past(i_warning_events) & 16'h70fe) == ($past(i_warning_events) & 16'h70fe))
      else $error("warning event not latched");
   a_no_spont_set: assert property (1'b1 |=> (o_link_warning_status & ~$past(o_link_warning_status)
      & ~$past(i_warning_events) & 16'h70fe) == 16'h0)
      else $error("warning bit set without event");
   a_phlim_hold: assert property (o_link_warning_status[4] && !seen_ff && !i_mgmt_clear_faults
      |=> o_link_warning_status[4])
      else $error("phase limit bit cleared without management clear");
   a_warn_pull: assert property ((idle_ff == 4'hf && |o_link_warning_status[14:1] && !mute) [*2]
      |-> !o_link_sdata)
      else $error("data line not pulled low on warning");
   a_target_clamp: assert property (i_operation_field == 4'hc && $past(i_operation_field) == 4'hc
      && $changed(o_vout_target_ff[15:0])
      |-> o_vout_target_ff[15:0] >= VOUT_MIN && o_vout_target_ff[15:0] <= VOUT_MAX)
      else $error("voltage target outside limits");
   a_follow_init: assert property (i_operation_field != 4'hc
      |=> o_vout_target_ff[15:0] == $past(i_init_voltage))
      else $error("target moved while link not owner");
endmodule // avsr_chk

bind avsr_responder avsr_chk #(.VOUT_MIN(VOUT_MIN), .VOUT_MAX(VOUT_MAX)) u_chk (
   .i_clock(i_clock), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk),
   .o_link_sdata(o_link_sdata), .i_latchoff_fault(i_latchoff_fault),
   .i_conversion_enabled(i_conversion_enabled), .i_mgmt_clear_faults(i_mgmt_clear_faults),
   .i_operation_field(i_operation_field), .i_warning_events(i_warning_events),
   .i_init_voltage(i_init_voltage), .o_link_warning_status(o_link_warning_status),
   .o_vout_target_ff(o_vout_target_ff));
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the link responder
// assumes the host model drives the link pins; checker is bound in
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
   localparam logic [15:0] VMIN  = 16'd250;
   localparam logic [15:0] VMAX  = 16'd5500;
   localparam logic [15:0] BOOTA = 16'd880;
   localparam logic [15:0] BOOTB = 16'd1000;
   localparam logic [4:0]  ST    = 5'b00100;
   logic        i_clock, i_reset_n, lclk, mdata, sdata, latch, rpin, busy, mclr, conv;
   logic [3:0]  op_field;
   logic [1:0]  settled;
   logic [15:0] init_v, events, status;
   logic [31:0] current, temper, target, slew, r;
   int          miscompares, compares;

   avsr_host_model u_host (.i_clock(i_clock), .i_link_sdata(sdata), .o_link_clk(lclk),
      .o_link_mdata(mdata));
   avsr_responder #(.VOUT_MIN(VMIN), .VOUT_MAX(VMAX)) u_dut (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_link_clk(lclk), .i_link_mdata(mdata),
      .o_link_sdata(sdata), .i_latchoff_fault(latch), .i_conversion_enabled(conv),
      .i_reset_pin_low(rpin), .i_operation_field(op_field), .i_settled(settled),
      .i_current(current), .i_temperature(temper), .i_boot_voltage_a(BOOTA),
      .i_boot_voltage_b(BOOTB), .i_init_voltage(init_v), .i_init_slew(16'h0505),
      .i_busy(busy), .i_warning_events(events), .i_mgmt_clear_faults(mclr),
      .o_link_warning_status(status), .o_vout_target_ff(target), .o_slew_ff(slew),
      .o_dynamic_voltage_change_ff());

   // -------------------------------------------------------------
   // frame helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] fr(input logic [28:0] b);
      logic [2:0] c;
      logic       f;
      c = 3'h0;
      for (int i = 28; i >= 0; i--)
      begin
         f = b[i] ^ c[2];
         c = {c[1], c[0] ^ f, f};
      end
      return {b, c};
   endfunction
   function automatic logic [31:0] mk(input logic [1:0] a, input logic [3:0] t, s,
      input logic [15:0] d);
      return fr({2'b01, a, 1'b0, t, s, d});
   endfunction
   function automatic logic [31:0] rsp(input logic [1:0] k, input logic [4:0] st,
      input logic [15:0] d);
      return fr({k, 1'b0, st, d, 5'h1f});
   endfunction
   // the answer arrives during the next frame, so a non-start frame fetches it
   task automatic tr(input logic [31:0] f);
      logic [31:0] d;
      u_host.xfer(f, d);
      u_host.xfer(32'hffff_ffff, r);
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_owner;
      `CHK("status rst", 16'h0000, status)
      `CHK("tgt init", 16'd1000, target[15:0])
      tr(mk(2'b00, 4'h0, 4'h0, 16'd1300));
      `CHK("tgt not owner", 16'd1000, target[15:0])
      @(posedge i_clock) op_field <= 4'hc;
   endtask
   task automatic t_volt;
      tr(32'h4000_1907);
      `CHK("vset ack", rsp(2'b00, ST, 16'hffff), r)
      `CHK("tgt a", 16'd800, target[15:0])
      tr(mk(2'b01, 4'h0, 4'h0, 16'd1200));
      `CHK("held", 16'd800, target[15:0])
      tr(mk(2'b00, 4'h0, 4'h1, 16'd100));
      `CHK("clamp lo", VMIN, target[31:16])
      tr(mk(2'b00, 4'h0, 4'h1, 16'hffff));
      `CHK("clamp hi", VMAX, target[31:16])
      @(posedge i_clock) rpin <= 1'b1;
      tr(mk(2'b11, 4'h0, 4'h1, 16'hffff));
      `CHK("read b", rsp(2'b00, 5'b00110, VMAX), r)
      @(posedge i_clock) rpin <= 1'b0;
   endtask
   task automatic t_slew;
      tr(mk(2'b00, 4'h1, 4'hf, 16'h0a02));
      `CHK("slew all", 32'h0a02_0a02, slew)
      tr(mk(2'b00, 4'h1, 4'h1, 16'h0305));
      tr(mk(2'b11, 4'h1, 4'h0, 16'hffff));
      `CHK("slew rd", rsp(2'b00, ST, 16'h0a02), r)
      `CHK("slew b", 32'h0305_0a02, slew)
   endtask
   task automatic t_tele;
      @(posedge i_clock) settled <= 2'b11;
      tr(32'h7107_fff9);
      `CHK("current", 32'h1410_86f8, r)
      @(posedge i_clock) settled <= 2'b00;
      tr(mk(2'b11, 4'h3, 4'h1, 16'hffff));
      `CHK("temp", rsp(2'b00, ST, 16'hff62), r)
      tr(mk(2'b11, 4'h2, 4'hf, 16'hffff));
      `CHK("bcast cur", 2'b11, r[31:30])
      tr(mk(2'b11, 4'hf, 4'hf, 16'hffff));
      `CHK("version", rsp(2'b00, ST, 16'h0000), r)
      tr(mk(2'b11, 4'h5, 4'h0, 16'hffff));
      `CHK("pmode", rsp(2'b00, ST, 16'h0000), r)
   endtask
   task automatic t_err;
      tr(mk(2'b00, 4'h0, 4'h0, 16'd900) ^ 32'h1);
      `CHK("bad crc", 2'b10, r[31:30])
      @(posedge i_clock) busy <= 1'b1;
      tr(mk(2'b00, 4'h0, 4'h0, 16'd900));
      `CHK("busy", 2'b01, r[31:30])
      @(posedge i_clock) busy <= 1'b0;
      tr(fr({2'b01, 2'b11, 1'b1, 8'h00, 16'hffff}));
      `CHK("vendor", 2'b11, r[31:30])
      `CHK("no action", 16'd800, target[15:0])
      tr(mk(2'b00, 4'h4, 4'hf, 16'h0000));
      `CHK("vreset", {BOOTB, BOOTA}, target)
   endtask
   task automatic t_warn;
      @(posedge i_clock) events <= 16'h4010;
      @(posedge i_clock) events <= 16'h0000;
      repeat (30) @(posedge i_clock);
      `CHK("wstat", 16'h4010, status)
      `CHK("sdata low", 1'b0, sdata)
      tr(mk(2'b00, 4'he, 4'hf, 16'h4010));
      `CHK("w1c ack", rsp(2'b00, 5'b01100, 16'hffff), r)
      `CHK("phase kept", 16'h0010, status)
      @(posedge i_clock) mclr <= 1'b1;
      @(posedge i_clock) mclr <= 1'b0;
      tr(mk(2'b00, 4'he, 4'hf, 16'h0010));
      repeat (30) @(posedge i_clock);
      `CHK("wclr", 16'h0000, status)
      `CHK("sdata idle", 1'b1, sdata)
   endtask
   task automatic t_mute;
      @(posedge i_clock) latch <= 1'b1;
      tr(mk(2'b00, 4'h0, 4'h0, 16'd1200));
      `CHK("mute rsp", 32'hffff_ffff, r)
      `CHK("mute tgt", BOOTA, target[15:0])
      @(posedge i_clock) latch <= 1'b0;
      conv <= 1'b0;
      tr(mk(2'b00, 4'h0, 4'h0, 16'd1200));
      `CHK("off rsp", 32'hffff_ffff, r)
      `CHK("off tgt", BOOTA, target[15:0])
      @(posedge i_clock) conv <= 1'b1;
   endtask

   // -------------------------------------------------------------
   // clock, sequence, verdict
   // -------------------------------------------------------------
   task automatic print_verdict;
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   // inputs settled at time zero; targets follow init until the link owns them
   initial
   begin
      {i_reset_n, latch, rpin, busy, mclr, settled} = '0;
      {op_field, events, current} = '0;
      init_v = 16'd1000;
      conv = 1'b1;
      temper = 32'hff62_0358;
      miscompares = 0;
      compares = 0;
      repeat (3) @(posedge i_clock);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      current <= 32'h0000_1086;
      t_owner;
      t_volt;
      t_slew;
      t_tele;
      t_err;
      t_warn;
      t_mute;
      print_verdict;
   end

   // roughly four times the expected run
   initial
   begin
      repeat (48000) @(posedge i_clock);
      miscompares++;
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
